// File: include/lgp_defines.svh
`ifndef LGP_DEFINES_SVH
`define LGP_DEFINES_SVH

// Register indices; byte address is four times the index
`define LGP_IDX_CTRL 8'h04
`define LGP_IDX_STATUS 8'h0C
`define LGP_IDX_PIN0_CFG 8'h0D
`define LGP_IDX_PIN12_CFG 8'h0E
`define LGP_IDX_PIN_LEVEL 8'h1F

// Control register fields
`define LGP_CTRL_PORT_SEL_BIT 0
`define LGP_CTRL_ERR_RESET_BIT 5

// Status register fields
`define LGP_STAT_LINK_DETECT_BIT 0
`define LGP_STAT_LINK_LOST_BIT 4

// Pin configuration fields
`define LGP_PIN0_MODE_LSB 0
`define LGP_PIN0_VAL_BIT 3
`define LGP_PIN1_MODE_LSB 0
`define LGP_PIN1_VAL_BIT 3
`define LGP_PIN2_MODE_LSB 4
`define LGP_PIN2_VAL_BIT 7
`define LGP_REV_LSB 4

// Reset values
`define LGP_MODE_RST 3'h0
`define LGP_VAL_RST 1'h0
`define LGP_REV_ID_DEFAULT 4'h5

// Mode codes
`define LGP_MODE_OUT 3'h1
`define LGP_MODE_IN 3'h3
`define LGP_MODE_HOLD 3'h5
`define LGP_MODE_DEFAULT 3'h7

`endif

// File: include/lgp_pkg.sv
package lgp_pkg;

  // Decoded role of one pin
  typedef enum logic [2:0] {
    LGP_ROLE_FUNC,
    LGP_ROLE_HIZ,
    LGP_ROLE_OUT,
    LGP_ROLE_IN,
    LGP_ROLE_HOLD,
    LGP_ROLE_DEFAULT
  } lgp_role_t;

  // Maps a 3-bit mode field onto a role
  function automatic lgp_role_t lgp_decode_role(input logic [2:0] mode);
    lgp_role_t role;
    role = LGP_ROLE_FUNC;
    case (mode)
      3'h1: role = LGP_ROLE_OUT;
      3'h3: role = LGP_ROLE_IN;
      3'h5: role = LGP_ROLE_HOLD;
      3'h7: role = LGP_ROLE_DEFAULT;
      3'h2, 3'h6: role = LGP_ROLE_HIZ;
      default: role = LGP_ROLE_FUNC;
    endcase
    return role;
  endfunction

endpackage

// File: src/lgp_pin_drive.sv
`timescale 1ns/1ps
// Combinational drive decision for one pin
module lgp_pin_drive
  import lgp_pkg::*;
(
  // Configuration
  input wire logic [2:0] mode_in,
  input wire logic local_val_in,
  // Link side
  input wire logic remote_val_in,
  input wire logic link_lost_in,
  // Pin decision
  output logic out_val_out,
  output logic oe_n_out,
  output logic func_en_out
);

  lgp_role_t role;

  assign role = lgp_decode_role(mode_in);

  // Output enable is active low; hi-z and inputs never drive
  always_comb begin
    out_val_out = 1'b0;
    oe_n_out = 1'b1;
    func_en_out = 1'b0;
    case (role)
      LGP_ROLE_FUNC: begin
        func_en_out = 1'b1;
      end
      LGP_ROLE_HIZ: begin
        oe_n_out = 1'b1;
      end
      LGP_ROLE_OUT: begin
        oe_n_out = 1'b0;
        out_val_out = local_val_in;
      end
      LGP_ROLE_IN: begin
        oe_n_out = 1'b1;
      end
      LGP_ROLE_HOLD: begin
        // Held remote value already frozen upstream on link loss
        oe_n_out = 1'b0;
        out_val_out = remote_val_in;
      end
      LGP_ROLE_DEFAULT: begin
        oe_n_out = 1'b0;
        out_val_out = link_lost_in ? local_val_in : remote_val_in;
      end
      default: begin
        oe_n_out = 1'b1;
      end
    endcase
  end

endmodule // lgp_pin_drive

// File: src/lgp_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "lgp_defines.svh"

// Behaviour
// - Mode codes with low bits 00 leave the pin in its functional input role.
// - Mode codes with low bits 10 put the pin in high impedance, driving nothing.
// - Mode 001 makes the pin a local output and mode 011 a general input.
// - Mode 101 drives the remote value and holds the last one when the link is lost.
// - Mode 111 drives the remote value and falls back to the local bit on link loss.
// - The local bit drives the pin in local output mode and in mode 111 after link loss, 0 low and 1 high.
// - Every local output bit resets to 0 so local outputs start low.
// - Index 0x0D bits 2:0 and 3 configure pin 0 of the selected port.
// - Index 0x0E bits 6:4 and 7 configure pin 2 of the selected port.
// - Index 0x0E bits 2:0 and 3 configure pin 1 of the selected port.
// - Index 0x0D bits 7:4 read a fixed revision value and ignore writes.
// - A link-lost flag stays set until the error-reset control clears it.
module lgp_top
  import lgp_pkg::*;
#(
  // Arbitrary revision value
  parameter logic [3:0] REV_ID = `LGP_REV_ID_DEFAULT
)(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Link state per port, same clock domain
  input wire logic [1:0] link_up_in,
  input wire logic [1:0] remote_strobe_in,
  input wire logic [2:0] remote_val_port0_in,
  input wire logic [2:0] remote_val_port1_in,
  // First pin set
  input wire logic [2:0] general_pin_in,
  output logic [2:0] general_pin_out,
  output logic [2:0] general_pin_oe_n_out,
  output logic [2:0] general_pin_func_out,
  // Second pin set
  input wire logic [2:0] second_port_pin_in,
  output logic [2:0] second_port_pin_out,
  output logic [2:0] second_port_pin_oe_n_out,
  output logic [2:0] second_port_pin_func_out
);

  localparam int NPIN = 6;

  // Configuration storage, index is port*3 + pin
  logic [2:0] mode_ff [NPIN];
  logic val_ff [NPIN];
  logic [2:0] nxt_mode [NPIN];
  logic nxt_val [NPIN];

  // Remote value latches
  logic rem_ff [NPIN];
  logic nxt_rem [NPIN];

  // Port select and link tracking
  logic second_port_select_ff;
  logic [1:0] link_up_q_ff;
  logic [1:0] link_lost_ff;
  logic [1:0] nxt_link_lost;

  // Pin input synchronisers
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;

  // Registered pin drive
  logic [5:0] pin_out_ff;
  logic [5:0] pin_oe_n_ff;
  logic [5:0] pin_func_ff;
  logic [5:0] drv_val;
  logic [5:0] drv_oe_n;
  logic [5:0] drv_func;

  // APB decode
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic setup_phase;
  logic access_phase;
  logic wr_take;
  logic hit;
  logic [7:0] idx;
  logic lane0;
  logic err_reset;
  logic [2:0] base;

  // Byte address to register index
  function automatic logic [7:0] addr_to_idx(input logic [11:0] addr);
    return addr[9:2];
  endfunction

  // Whether an index names a register
  function automatic logic idx_mapped(input logic [7:0] i, input logic [1:0] a);
    return (a == 2'h0) && ((i == `LGP_IDX_CTRL) || (i == `LGP_IDX_STATUS) ||
           (i == `LGP_IDX_PIN0_CFG) || (i == `LGP_IDX_PIN12_CFG) ||
           (i == `LGP_IDX_PIN_LEVEL));
  endfunction

  assign idx = addr_to_idx(paddr_in);
  assign hit = idx_mapped(idx, paddr_in[1:0]);
  assign setup_phase = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;
  assign lane0 = pstrb_in[0];

  // Zero wait states; the read word is ready after the setup cycle
  assign pready_out = access_phase;
  assign pslverr_out = access_phase & ~hit;
  assign prdata_out = prdata_ff;

  // Writes take effect only at the access edge to a mapped byte lane
  assign wr_take = access_phase & pwrite_in & hit & lane0;
  assign err_reset = wr_take & (idx == `LGP_IDX_CTRL) & pwdata_in[`LGP_CTRL_ERR_RESET_BIT];

  // Configuration of the selected port is what software sees
  assign base = second_port_select_ff ? 3'h3 : 3'h0;

  // Port select register
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      second_port_select_ff <= 1'b0;
    end else if (wr_take && idx == `LGP_IDX_CTRL) begin
      second_port_select_ff <= pwdata_in[`LGP_CTRL_PORT_SEL_BIT];
    end
  end

  // Next configuration values from bus writes
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      nxt_mode[i] = mode_ff[i];
      nxt_val[i] = val_ff[i];
    end
    if (wr_take && idx == `LGP_IDX_PIN0_CFG) begin
      // Revision bits are not stored, so writes to them vanish
      nxt_mode[base] = pwdata_in[`LGP_PIN0_MODE_LSB +: 3];
      nxt_val[base] = pwdata_in[`LGP_PIN0_VAL_BIT];
    end
    if (wr_take && idx == `LGP_IDX_PIN12_CFG) begin
      nxt_mode[base + 3'h1] = pwdata_in[`LGP_PIN1_MODE_LSB +: 3];
      nxt_val[base + 3'h1] = pwdata_in[`LGP_PIN1_VAL_BIT];
      nxt_mode[base + 3'h2] = pwdata_in[`LGP_PIN2_MODE_LSB +: 3];
      nxt_val[base + 3'h2] = pwdata_in[`LGP_PIN2_VAL_BIT];
    end
  end

  // Configuration storage
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NPIN; i++) begin
        mode_ff[i] <= `LGP_MODE_RST;
        val_ff[i] <= `LGP_VAL_RST;
      end
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        mode_ff[i] <= nxt_mode[i];
        val_ff[i] <= nxt_val[i];
      end
    end
  end

  // Previous link state for falling edge detection
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_up_q_ff <= 2'h0;
    end else begin
      link_up_q_ff <= link_up_in;
    end
  end

  // Sticky link-lost flags; a new loss wins over a clear in the same cycle
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      nxt_link_lost[p] = link_lost_ff[p];
      if (err_reset && (second_port_select_ff == p[0])) begin
        nxt_link_lost[p] = 1'b0;
      end
      if (link_up_q_ff[p] && !link_up_in[p]) begin
        nxt_link_lost[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_lost_ff <= 2'h0;
    end else begin
      link_lost_ff <= nxt_link_lost;
    end
  end

  // Remote values follow each strobe only while the link is up
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      nxt_rem[i] = rem_ff[i];
    end
    for (int j = 0; j < 3; j++) begin
      if (remote_strobe_in[0] && link_up_in[0]) begin
        nxt_rem[j] = remote_val_port0_in[j];
      end
      if (remote_strobe_in[1] && link_up_in[1]) begin
        nxt_rem[j + 3] = remote_val_port1_in[j];
      end
    end
  end

  // Remote latches keep the last value once the link drops
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NPIN; i++) begin
        rem_ff[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        rem_ff[i] <= nxt_rem[i];
      end
    end
  end

  // Pin levels come from outside the clock domain
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_meta_ff <= 6'h00;
      pin_sync_ff <= 6'h00;
    end else begin
      pin_meta_ff <= {second_port_pin_in, general_pin_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // One drive decision per pin
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    lgp_pin_drive u_drive (
      .mode_in(mode_ff[g]),
      .local_val_in(val_ff[g]),
      .remote_val_in(rem_ff[g]),
      .link_lost_in(link_lost_ff[g / 3]),
      .out_val_out(drv_val[g]),
      .oe_n_out(drv_oe_n[g]),
      .func_en_out(drv_func[g])
    );
  end

  // Pin drive registers; reset leaves every pin in its functional role
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_out_ff <= 6'h00;
      pin_oe_n_ff <= 6'h3F;
      pin_func_ff <= 6'h3F;
    end else begin
      pin_out_ff <= drv_val;
      pin_oe_n_ff <= drv_oe_n;
      pin_func_ff <= drv_func;
    end
  end

  assign general_pin_out = pin_out_ff[2:0];
  assign general_pin_oe_n_out = pin_oe_n_ff[2:0];
  assign general_pin_func_out = pin_func_ff[2:0];
  assign second_port_pin_out = pin_out_ff[5:3];
  assign second_port_pin_oe_n_out = pin_oe_n_ff[5:3];
  assign second_port_pin_func_out = pin_func_ff[5:3];

  // Read word assembled from the selected port's view, except pin levels, which show both ports
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit) begin
      case (idx)
        `LGP_IDX_CTRL: begin
          nxt_prdata[`LGP_CTRL_PORT_SEL_BIT] = second_port_select_ff;
        end
        `LGP_IDX_STATUS: begin
          nxt_prdata[`LGP_STAT_LINK_DETECT_BIT] = link_up_in[second_port_select_ff];
          nxt_prdata[`LGP_STAT_LINK_LOST_BIT] = link_lost_ff[second_port_select_ff];
        end
        `LGP_IDX_PIN0_CFG: begin
          nxt_prdata[`LGP_PIN0_MODE_LSB +: 3] = mode_ff[base];
          nxt_prdata[`LGP_PIN0_VAL_BIT] = val_ff[base];
          nxt_prdata[`LGP_REV_LSB +: 4] = REV_ID;
        end
        `LGP_IDX_PIN12_CFG: begin
          nxt_prdata[`LGP_PIN1_MODE_LSB +: 3] = mode_ff[base + 3'h1];
          nxt_prdata[`LGP_PIN1_VAL_BIT] = val_ff[base + 3'h1];
          nxt_prdata[`LGP_PIN2_MODE_LSB +: 3] = mode_ff[base + 3'h2];
          nxt_prdata[`LGP_PIN2_VAL_BIT] = val_ff[base + 3'h2];
        end
        `LGP_IDX_PIN_LEVEL: begin
          // Levels of input-mode pins; other pins read their pad too
          nxt_prdata[2:0] = pin_sync_ff[2:0];
          nxt_prdata[6:4] = pin_sync_ff[5:3];
        end
        default: begin
          nxt_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data captured in the setup cycle, so the access phase needs no wait
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase && !pwrite_in) begin
      prdata_ff <= nxt_prdata;
    end
  end

endmodule // lgp_top

// File: dv/lgp_asserts.sv
`timescale 1ns/1ps
// Ties first-port pin decisions to configuration writes seen on the bus
module lgp_asserts #(
  parameter logic [3:0] REV_ID = 4'h5
)(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Bus
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  // Link and pins
  input wire logic [1:0] link_up_in,
  input wire logic [2:0] general_pin_out,
  input wire logic [2:0] general_pin_oe_n_out,
  input wire logic [2:0] general_pin_func_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic wr, w0, w12, sel_ff;
  logic [3:0] c0_ff;
  // Pin configuration writes only count while the first port is selected
  assign wr = psel_in && penable_in && pwrite_in && pstrb_in[0];
  assign w0 = wr && !sel_ff && paddr_in == 12'h034;
  assign w12 = wr && !sel_ff && paddr_in == 12'h038;
  // Port select shadow
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) sel_ff <= 1'b0;
    else if (wr && paddr_in == 12'h010) sel_ff <= pwdata_in[0];
  end
  // Pin 0 mode and value shadow, needed for the link-loss checks
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) c0_ff <= 4'h0;
    else if (w0) c0_ff <= pwdata_in[3:0];
  end
  property p_func; w0 && pwdata_in[1:0] == 2'h0 |-> ##2 general_pin_func_out[0]; endproperty
  a_func: assert property (p_func) else $error("pin 0 not functional");
  property p_hiz; w0 && pwdata_in[1:0] == 2'h2 |-> ##2 general_pin_oe_n_out[0]; endproperty
  a_hiz: assert property (p_hiz) else $error("pin 0 driven in high impedance");
  property p_gpo;
    w0 && pwdata_in[2:0] == 3'h1 |-> ##2
      !general_pin_oe_n_out[0] && general_pin_out[0] == $past(pwdata_in[3], 2);
  endproperty
  a_gpo: assert property (p_gpo) else $error("pin 0 local output wrong");
  property p_gpi;
    w0 && pwdata_in[2:0] == 3'h3 |-> ##2 general_pin_oe_n_out[0] && !general_pin_func_out[0];
  endproperty
  a_gpi: assert property (p_gpi) else $error("pin 0 input mode wrong");
  property p_pin1;
    w12 && pwdata_in[2:0] == 3'h1 |-> ##2
      !general_pin_oe_n_out[1] && general_pin_out[1] == $past(pwdata_in[3], 2);
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin 1 output wrong");
  property p_pin2;
    w12 && pwdata_in[6:4] == 3'h1 |-> ##2
      !general_pin_oe_n_out[2] && general_pin_out[2] == $past(pwdata_in[7], 2);
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 output wrong");
  property p_rev;
    psel_in && penable_in && !pwrite_in && paddr_in == 12'h034 |-> prdata_out[7:4] == REV_ID;
  endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");
  property p_hold;
    c0_ff[2:0] == 3'h5 && $fell(link_up_in[0]) |-> ##2
      general_pin_out[0] == $past(general_pin_out[0], 2);
  endproperty
  a_hold: assert property (p_hold) else $error("held value lost");
  property p_dflt;
    c0_ff[2:0] == 3'h7 && $fell(link_up_in[0]) |-> ##2 general_pin_out[0] == c0_ff[3];
  endproperty
  a_dflt: assert property (p_dflt) else $error("local value not used");
endmodule // lgp_asserts

bind lgp_top lgp_asserts #(.REV_ID(REV_ID)) u_chk (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .link_up_in(link_up_in), .general_pin_out(general_pin_out),
  .general_pin_oe_n_out(general_pin_oe_n_out), .general_pin_func_out(general_pin_func_out));

// File: dv/lgp_remote_model.sv
`timescale 1ns/1ps
// Far-side deserializer: link state and back-channel pin values
module lgp_remote_model (
  // Clock
  input wire logic clk_in,
  // Back channel
  output logic [1:0] link_up_out,
  output logic [1:0] strobe_out,
  output logic [2:0] val0_out,
  output logic [2:0] val1_out
);
  initial begin
    link_up_out = 2'h3;
    strobe_out = 2'h0;
    val0_out = 3'h0;
    val1_out = 3'h0;
  end
  // Values are inverted outside the strobe so stale data never passes
  task automatic send(input logic [2:0] v);
    val0_out <= v;
    strobe_out <= 2'h1;
    @(posedge clk_in);
    strobe_out <= 2'h0;
    val0_out <= ~v;
  endtask
  // Second port back channel, same inversion outside the strobe
  task automatic send1(input logic [2:0] v);
    val1_out <= v;
    strobe_out <= 2'h2;
    @(posedge clk_in);
    strobe_out <= 2'h0;
    val1_out <= ~v;
  endtask
  // Link state of the first port
  task automatic link(input logic up);
    link_up_out[0] <= up;
    @(posedge clk_in);
  endtask
endmodule // lgp_remote_model

// File: dv/testbench.sv
`timescale 1ns/1ps
// Programs pin modes over the bus and checks pin roles and values
module testbench;
  logic clk, rstn, psel, pen, pwr, rerr, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] lup, stb;
  logic [3:0] pstrb, lane;
  logic [2:0] rv0, rv1, gin, sin, gout, goe, gfn, sout, soe, sfn;
  int fail_count, compares;
  lgp_top i_dut (.sys_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .link_up_in(lup), .remote_strobe_in(stb), .remote_val_port0_in(rv0),
    .remote_val_port1_in(rv1), .general_pin_in(gin), .general_pin_out(gout),
    .general_pin_oe_n_out(goe), .general_pin_func_out(gfn), .second_port_pin_in(sin),
    .second_port_pin_out(sout), .second_port_pin_oe_n_out(soe),
    .second_port_pin_func_out(sfn));
  lgp_remote_model i_rem (.clk_in(clk), .link_up_out(lup), .strobe_out(stb),
    .val0_out(rv0), .val1_out(rv1));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer; the request holds until pready is seen
  // Only the watchdog ends a wait; one idle edge keeps strobes from being driven twice
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= lane;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Pin 0 as {functional, not driving, value}; value masked when not driving
  task automatic pin0(input logic [2:0] e);
    chk({29'h0, gfn[0], goe[0], goe[0] ? 1'b0 : gout[0]}, {29'h0, e});
  endtask
  // Local value 1, remote value 0
  function automatic logic [2:0] exp0(input logic [2:0] m);
    logic drv;
    drv = m == 3'h1 || m == 3'h5 || m == 3'h7;
    return {m[1:0] == 2'h0, !drv, m == 3'h1};
  endfunction
  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20us;
    fail_count++;
    conclude();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    lane = 4'hF;
    gin = 3'h5;
    sin = 3'h2;
    fail_count = 0;
    compares = 0;
    cyc(4);
    rstn <= 1'b1;
    cyc(1);
    chk({14'h0, sout, soe, sfn, gout, goe, gfn}, 32'h07E3F);
    bus(1'b0, 12'h034, 8'h00);
    chk(rdat, 32'h50);
    bus(1'b0, 12'h038, 8'h00);
    chk(rdat, 32'h0);
    bus(1'b0, 12'h07C, 8'h00);
    chk(rdat, 32'h25);
    i_rem.send(3'h0);
    // Every mode code, with the read-only bits written as ones
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 12'h034, {5'h1F, m[2:0]});
      bus(1'b0, 12'h034, 8'h00);
      chk(rdat, {24'h0, 5'h0B, m[2:0]});
      pin0(exp0(m[2:0]));
    end
    bus(1'b1, 12'h038, 8'h91);
    cyc(2);
    chk({28'h0, goe[2:1], gout[2:1]}, 32'h2);
    bus(1'b1, 12'h038, 8'h19);
    bus(1'b0, 12'h038, 8'h00);
    chk(rdat, 32'h19);
    chk({28'h0, goe[2:1], gout[2:1]}, 32'h1);
    // Remote-default: follows arrivals, falls back to local bit on loss
    bus(1'b1, 12'h034, 8'h0F);
    i_rem.send(3'h1);
    cyc(2);
    pin0(3'h1);
    i_rem.send(3'h0);
    cyc(2);
    pin0(3'h0);
    i_rem.link(1'b0);
    cyc(2);
    pin0(3'h1);
    bus(1'b0, 12'h030, 8'h00);
    chk(rdat & 32'h11, 32'h10);
    bus(1'b1, 12'h010, 8'h20);
    bus(1'b0, 12'h030, 8'h00);
    chk(rdat & 32'h11, 32'h0);
    i_rem.link(1'b1);
    i_rem.send(3'h0);
    cyc(2);
    pin0(3'h0);
    // Remote-hold keeps the last value; arrivals without link are ignored
    bus(1'b1, 12'h034, 8'h0D);
    i_rem.send(3'h1);
    cyc(2);
    pin0(3'h1);
    i_rem.link(1'b0);
    i_rem.send(3'h0);
    cyc(2);
    pin0(3'h1);
    i_rem.link(1'b1);
    bus(1'b1, 12'h010, 8'h20);
    // Second port takes the same fields; first port untouched
    bus(1'b1, 12'h010, 8'h01);
    bus(1'b1, 12'h034, 8'h09);
    bus(1'b0, 12'h034, 8'h00);
    chk(rdat, 32'h59);
    chk({26'h0, sfn[0], soe[0], sout[0], gfn[0], goe[0], gout[0]}, 32'h9);
    // Second port remote-default follows its own back channel
    bus(1'b1, 12'h034, 8'h07);
    i_rem.send1(3'h1);
    cyc(2);
    chk({29'h0, sfn[0], soe[0], sout[0]}, 32'h1);
    bus(1'b1, 12'h010, 8'h00);
    bus(1'b0, 12'h100, 8'h00);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    // A write without the low byte lane is dropped
    lane = 4'hE;
    bus(1'b1, 12'h034, 8'h02);
    lane = 4'hF;
    bus(1'b0, 12'h034, 8'h00);
    chk(rdat, 32'h5D);
    // Pad levels pass the synchroniser
    gin <= 3'h2;
    sin <= 3'h5;
    cyc(3);
    bus(1'b0, 12'h07C, 8'h00);
    chk(rdat, 32'h52);
    conclude();
  end
endmodule // testbench
